//--- sfp_seq.sv
// Self-programming sequencer: command window, page mapping, area guards
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps

// How it works
// - Small variant: fuse picks 128..1024-word boot section
// - Middle variant: fuse picks 256..2048-word boot section
// - Large variant: fuse picks 512..4096-word boot section
// - Small variant: stalling area from 0x1C00 up
// - Middle variant: stalling area from 0x3800 up
// - Large variant: stalling area from 0x7000 up
// - PC width 13, 14 or 15 bits
// - Page select from pointer bits above word field
// - Word select from pointer bits starting at one
// - Pointer bit zero ignored; byte select on loads
// - Enable opens four-cycle window, then auto-clears
// - Read-area page operation sets busy, blocks reads
// - Stalling-area page operation halts the CPU
// - Only five command codes take effect
module sfp_seq
    import sfp_pkg::*;
#(
    parameter int VARIANT = SFP_VAR_SMALL,
    localparam int PC_W   = SFP_PC_W[VARIANT],
    localparam int WORD_W = SFP_WORD_W[VARIANT],
    localparam int PAGE_W = PC_W - WORD_W
)
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              boot_size_sel_hi,
    input  wire logic              boot_size_sel_lo,
    input  wire logic [SFP_ADDR_W-1:0] bus_addr,
    input  wire logic [31:0]       bus_wdata,
    input  wire logic              bus_we,
    input  wire logic              bus_re,
    output logic      [31:0]       bus_rdata,
    input  wire logic              spm_exec,
    input  wire logic              lpm_req,
    input  wire logic [15:0]       pointer_z,
    input  wire logic [15:0]       store_data,
    input  wire logic              flash_done,
    output logic                   store_prog_enable,
    output logic                   read_area_busy,
    output logic                   cpu_halt,
    output logic                   fill_strobe,
    output logic                   erase_strobe,
    output logic                   write_strobe,
    output logic                   lock_strobe,
    output logic      [WORD_W-1:0] word_select_field,
    output logic      [PAGE_W-1:0] page_select_field,
    output logic      [15:0]       store_data_out,
    output logic                   read_blocked,
    output logic                   byte_select_bit,
    output logic      [15:0]       boot_reset_addr,
    output logic      [15:0]       app_end_addr
);
    import sfp_pkg::*;

    typedef enum logic [2:0] {
        SFP_IDLE  = 3'b001,
        SFP_ARMED = 3'b010,
        SFP_BUSY  = 3'b100
    } sfp_state_e;

    typedef struct packed {
        sfp_state_e        st;
        logic [4:0]        cmd;
        logic              en;
        logic              area_busy;
        logic              halt;
        logic              fill;
        logic              erase;
        logic              write;
        logic              lock;
        logic [WORD_W-1:0] word;
        logic [PAGE_W-1:0] page;
        logic [15:0]       data;
        logic              blocked;
        logic              byte_hi;
        logic [31:0]       rdata;
        logic [1:0]        sz_meta;
        logic [1:0]        sz_sync;
        logic [15:0]       boot_start;
        logic [15:0]       app_end;
    } sfp_seq_s;

    sfp_seq_s s_q;
    sfp_seq_s s_d;

    logic [15:0] map_boot_start;
    logic [15:0] map_app_end;
    logic [15:0] map_stall_start;
    logic        win_active;
    logic        win_open;
    logic        win_take;
    logic        cmd_valid;
    logic [15:0] z_word;
    logic [15:0] lpm_word;
    logic        z_in_stall;

    sfp_boot_map #(
        .VARIANT (VARIANT)
    ) u_map (
        .boot_size_sel (s_q.sz_sync),
        .boot_start    (map_boot_start),
        .app_end       (map_app_end),
        .stall_start   (map_stall_start)
    );

    sfp_window u_win (
        .clk      (clk),
        .resetn   (resetn),
        .open_win (win_open),
        .take     (win_take),
        .active   (win_active)
    );

    // Word address carried by the pointer; bit zero is the byte lane
    assign z_word     = {1'b0, pointer_z[15:1]} &
                        SFP_MEM_TOP[VARIANT];
    assign lpm_word   = z_word;
    assign z_in_stall = (z_word >= map_stall_start);

    always_comb
    begin
        cmd_valid = (bus_wdata[4:0] == SFP_CMD_REENABLE) ||
                    (bus_wdata[4:0] == SFP_CMD_LOCKSET)  ||
                    (bus_wdata[4:0] == SFP_CMD_PGWRITE)  ||
                    (bus_wdata[4:0] == SFP_CMD_PGERASE)  ||
                    (bus_wdata[4:0] == SFP_CMD_FILL);
    end

    // A new command is only taken while nothing is pending or running
    assign win_open = bus_we && (bus_addr == SFP_CTRL_OFS) && cmd_valid &&
                      (s_q.st == SFP_IDLE);
    assign win_take = spm_exec && (s_q.st == SFP_ARMED) && win_active;

    always_comb
    begin
        s_d       = s_q;
        s_d.fill  = 1'b0;
        s_d.erase = 1'b0;
        s_d.write = 1'b0;
        s_d.lock  = 1'b0;

        // Fuse pins are static but asynchronous to the core clock
        s_d.sz_meta    = {boot_size_sel_hi, boot_size_sel_lo};
        s_d.sz_sync    = s_q.sz_meta;
        s_d.boot_start = map_boot_start;
        s_d.app_end    = map_app_end;

        case (s_q.st)
            SFP_IDLE:
            begin
                if (win_open)
                begin
                    s_d.st  = SFP_ARMED;
                    s_d.cmd = bus_wdata[4:0];
                    s_d.en  = 1'b1;
                end
            end
            SFP_ARMED:
            begin
                if (win_take)
                begin
                    s_d.st  = SFP_IDLE;
                    s_d.en  = 1'b0;
                    s_d.cmd = 5'h00;
                    case (s_q.cmd)
                        SFP_CMD_FILL:
                        begin
                            s_d.fill      = 1'b1;
                            s_d.word      = z_word[WORD_W-1:0];
                            s_d.data      = store_data;
                            s_d.area_busy = 1'b0;
                        end
                        SFP_CMD_PGERASE,
                        SFP_CMD_PGWRITE:
                        begin
                            s_d.st    = SFP_BUSY;
                            s_d.en    = 1'b1;
                            s_d.cmd   = s_q.cmd;
                            s_d.erase = (s_q.cmd == SFP_CMD_PGERASE);
                            s_d.write = (s_q.cmd == SFP_CMD_PGWRITE);
                            s_d.page  = z_word[PC_W-1:WORD_W];
                            if (z_in_stall)
                            begin
                                s_d.halt = 1'b1;
                            end
                            else
                            begin
                                s_d.area_busy = 1'b1;
                            end
                        end
                        SFP_CMD_LOCKSET:
                        begin
                            s_d.lock = 1'b1;
                            s_d.data = store_data;
                        end
                        SFP_CMD_REENABLE:
                        begin
                            s_d.area_busy = 1'b0;
                        end
                        default:
                        begin
                            s_d.cmd = 5'h00;
                        end
                    endcase
                end
                else if (!win_active && !win_open)
                begin
                    // Window ran out without a store instruction
                    s_d.st  = SFP_IDLE;
                    s_d.en  = 1'b0;
                    s_d.cmd = 5'h00;
                end
            end
            SFP_BUSY:
            begin
                if (flash_done)
                begin
                    s_d.st   = SFP_IDLE;
                    s_d.en   = 1'b0;
                    s_d.cmd  = 5'h00;
                    s_d.halt = 1'b0;
                end
            end
            default:
            begin
                s_d.st  = SFP_IDLE;
                s_d.en  = 1'b0;
                s_d.cmd = 5'h00;
            end
        endcase

        if (lpm_req)
        begin
            s_d.byte_hi = pointer_z[0];
            s_d.blocked = s_d.area_busy &&
                          (lpm_word < map_stall_start);
        end

        s_d.rdata = SFP_RDATA_RST;
        if (bus_re)
        begin
            case (bus_addr)
                SFP_CTRL_OFS:
                begin
                    s_d.rdata[4:0]          = s_q.cmd;
                    s_d.rdata[SFP_EN_BIT]   = s_q.en;
                    s_d.rdata[SFP_BUSY_BIT] = s_q.area_busy;
                end
                SFP_MAP_OFS:
                begin
                    s_d.rdata = {s_q.app_end, s_q.boot_start};
                end
                SFP_AREA_OFS:
                begin
                    s_d.rdata = {map_stall_start, 8'h00, 8'(PC_W - 1)};
                end
                default:
                begin
                    s_d.rdata = SFP_RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s_q     <= '0;
            s_q.st  <= SFP_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign bus_rdata         = s_q.rdata;
    assign store_prog_enable = s_q.en;
    assign read_area_busy    = s_q.area_busy;
    assign cpu_halt          = s_q.halt;
    assign fill_strobe       = s_q.fill;
    assign erase_strobe      = s_q.erase;
    assign write_strobe      = s_q.write;
    assign lock_strobe       = s_q.lock;
    assign word_select_field = s_q.word;
    assign page_select_field = s_q.page;
    assign store_data_out    = s_q.data;
    assign read_blocked      = s_q.blocked;
    assign byte_select_bit   = s_q.byte_hi;
    assign boot_reset_addr   = s_q.boot_start;
    assign app_end_addr      = s_q.app_end;

endmodule

//--- sfp_pkg.sv
// Shared constants for the self-programming address map and sequencer
package sfp_pkg;

    // Memory variants
    localparam int SFP_VAR_SMALL = 0;
    localparam int SFP_VAR_MID   = 1;
    localparam int SFP_VAR_LARGE = 2;

    // Per variant: program counter width, word-select width
    localparam int SFP_PC_W   [3] = '{13, 14, 15};
    localparam int SFP_WORD_W [3] = '{6, 6, 7};

    // Boot section start, indexed [variant][boot size select value]
    localparam logic [15:0] SFP_BOOT_START [3][4] = '{
        '{16'h1c00, 16'h1e00, 16'h1f00, 16'h1f80},
        '{16'h3800, 16'h3c00, 16'h3e00, 16'h3f00},
        '{16'h7000, 16'h7800, 16'h7c00, 16'h7e00}
    };

    // First word of the stalling area and last flash word per variant
    localparam logic [15:0] SFP_STALL_START [3] = '{16'h1c00, 16'h3800,
                                                    16'h7000};
    localparam logic [15:0] SFP_MEM_TOP     [3] = '{16'h1fff, 16'h3fff,
                                                    16'h7fff};

    // Store-program enable window, in core clock cycles
    localparam logic [2:0] SFP_WINDOW_CYCLES = 3'h4;

    // Command codes in the low five control bits
    localparam logic [4:0] SFP_CMD_REENABLE = 5'h11;
    localparam logic [4:0] SFP_CMD_LOCKSET  = 5'h09;
    localparam logic [4:0] SFP_CMD_PGWRITE  = 5'h05;
    localparam logic [4:0] SFP_CMD_PGERASE  = 5'h03;
    localparam logic [4:0] SFP_CMD_FILL     = 5'h01;

    // Register bus
    localparam int         SFP_ADDR_W     = 8;
    localparam logic [7:0] SFP_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SFP_MAP_OFS    = 8'h04;
    localparam logic [7:0] SFP_AREA_OFS   = 8'h08;
    localparam int         SFP_EN_BIT     = 0;
    localparam int         SFP_BUSY_BIT   = 6;
    localparam logic [31:0] SFP_RDATA_RST = 32'h0000_0000;

endpackage

//--- sfp_boot_map.sv
// Boot size select decode into boot section start and application end
`timescale 1ns/10ps
module sfp_boot_map
    import sfp_pkg::*;
#(
    parameter int VARIANT = SFP_VAR_SMALL
)
(
    input  wire logic [1:0]  boot_size_sel,
    output logic      [15:0] boot_start,
    output logic      [15:0] app_end,
    output logic      [15:0] stall_start
);
    import sfp_pkg::*;

    assign boot_start  = SFP_BOOT_START[VARIANT][boot_size_sel];
    assign app_end     = boot_start - 16'h0001;
    assign stall_start = SFP_STALL_START[VARIANT];

endmodule

//--- sfp_window.sv
// Four-cycle enable window counter for the store-program instruction
`timescale 1ns/10ps
module sfp_window
    import sfp_pkg::*;
(
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic open_win,
    input  wire logic take,
    output logic      active
);
    import sfp_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
    } sfp_win_s;

    sfp_win_s s_q;
    sfp_win_s s_d;

    always_comb
    begin
        s_d = s_q;
        if (open_win)
        begin
            s_d.cnt = SFP_WINDOW_CYCLES;
        end
        else if (take)
        begin
            s_d.cnt = 3'h0;
        end
        else if (s_q.cnt != 3'h0)
        begin
            s_d.cnt = s_q.cnt - 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign active = (s_q.cnt != 3'h0);

endmodule

//--- sfp_seq_sva.sv
// Port assertions for the self-programming sequencer
`timescale 1ns/10ps
module sfp_seq_chk
    import sfp_pkg::*;
#(
    parameter int  VARIANT = SFP_VAR_SMALL,
    localparam int PC_W    = SFP_PC_W[VARIANT],
    localparam int WORD_W  = SFP_WORD_W[VARIANT],
    localparam int PAGE_W  = PC_W - WORD_W
)
(
    input logic              clk,
    input logic              resetn,
    input logic              boot_size_sel_hi,
    input logic              boot_size_sel_lo,
    input logic [7:0]        bus_addr,
    input logic [31:0]       bus_wdata,
    input logic              bus_we,
    input logic              spm_exec,
    input logic              lpm_req,
    input logic [15:0]       pointer_z,
    input logic              flash_done,
    input logic              store_prog_enable,
    input logic              read_area_busy,
    input logic              cpu_halt,
    input logic              fill_strobe,
    input logic              erase_strobe,
    input logic              write_strobe,
    input logic [WORD_W-1:0] word_select_field,
    input logic [PAGE_W-1:0] page_select_field,
    input logic              read_blocked,
    input logic              byte_select_bit,
    input logic [15:0]       boot_reset_addr,
    input logic [15:0]       app_end_addr
);
    import sfp_pkg::*;

    logic [1:0] sel;
    logic       st;
    assign sel = {boot_size_sel_hi, boot_size_sel_lo};
    // Word address at or above the stalling boundary
    assign st  = pointer_z[PC_W:1] >= SFP_STALL_START[VARIANT];

    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);

    en_cause_a: assert property (
        $rose(store_prog_enable) |-> $past(bus_we)
        && $past(bus_addr) == SFP_CTRL_OFS && $past(bus_wdata[4:0])
        inside {5'h11, 5'h09, 5'h05, 5'h03, 5'h01})
        else $error("enable set without valid command");
    win_end_a: assert property (
        $rose(store_prog_enable) ##0 (!spm_exec)[*4]
        |-> ##2 !store_prog_enable)
        else $error("unused window did not close");
    fill_word_a: assert property (
        fill_strobe |-> $past(spm_exec)
        && word_select_field == $past(pointer_z[WORD_W:1]))
        else $error("fill word select wrong");
    page_sel_a: assert property (
        erase_strobe || write_strobe
        |-> page_select_field == $past(pointer_z[PC_W:WORD_W+1]))
        else $error("page select wrong");
    area_kind_a: assert property (
        erase_strobe || write_strobe
        |-> cpu_halt == $past(st) && ($past(st) || read_area_busy))
        else $error("halt or busy wrong");
    load_block_a: assert property (
        lpm_req && read_area_busy && !st |=> read_blocked)
        else $error("busy area load not blocked");
    byte_sel_a: assert property (
        lpm_req |=> byte_select_bit == $past(pointer_z[0]))
        else $error("byte select wrong");
    halt_end_a: assert property (
        cpu_halt && flash_done |=> !cpu_halt && !store_prog_enable)
        else $error("halt held after flash done");
    boot_map_a: assert property (
        $stable(sel)[*4]
        |-> boot_reset_addr == SFP_BOOT_START[VARIANT][sel]
        && app_end_addr == boot_reset_addr - 16'h0001)
        else $error("boot map wrong");

    erase_c: cover property (erase_strobe && read_area_busy);
    halt_c: cover property ($rose(cpu_halt));
    fill_c: cover property (fill_strobe);
endmodule

bind sfp_seq sfp_seq_chk #(.VARIANT(VARIANT)) u_sfp_seq_chk (
    .clk(clk), .resetn(resetn), .boot_size_sel_hi(boot_size_sel_hi),
    .boot_size_sel_lo(boot_size_sel_lo), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .spm_exec(spm_exec),
    .lpm_req(lpm_req), .pointer_z(pointer_z), .flash_done(flash_done),
    .store_prog_enable(store_prog_enable), .cpu_halt(cpu_halt),
    .read_area_busy(read_area_busy), .fill_strobe(fill_strobe),
    .erase_strobe(erase_strobe), .write_strobe(write_strobe),
    .word_select_field(word_select_field),
    .page_select_field(page_select_field), .read_blocked(read_blocked),
    .byte_select_bit(byte_select_bit), .boot_reset_addr(boot_reset_addr),
    .app_end_addr(app_end_addr)
);

//--- sfp_cpu_model.sv
// Core and flash macro model beside the self-programming sequencer
`timescale 1ns/10ps
module sfp_cpu_model
(
    input  logic        clk,
    input  logic        erase_strobe,
    input  logic        write_strobe,
    output logic        spm_exec,
    output logic        lpm_req,
    output logic [15:0] pointer_z,
    output logic [15:0] store_data,
    output logic        flash_done
);
    int dly;
    int cnt;

    initial
    begin
        spm_exec   = 1'b0;
        lpm_req    = 1'b0;
        pointer_z  = 16'h0000;
        store_data = 16'h0000;
        flash_done = 1'b0;
        dly        = 2;
        cnt        = 0;
    end

    // Flash busy time set by the bench: prompt or slow
    always @(posedge clk)
    begin
        flash_done <= (cnt == 1);
        if (erase_strobe || write_strobe)
            cnt <= dly;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end

    // Released pointer shows its inverse so stale values cannot match
    task automatic store(input logic [15:0] zz, input logic [15:0] dd);
        spm_exec   <= 1'b1;
        pointer_z  <= zz;
        store_data <= dd;
        @(posedge clk);
        spm_exec  <= 1'b0;
        pointer_z <= ~zz;
    endtask

    task automatic load(input logic [15:0] zz);
        lpm_req   <= 1'b1;
        pointer_z <= zz;
        @(posedge clk);
        lpm_req   <= 1'b0;
        pointer_z <= ~zz;
    endtask
endmodule

//--- test_self_program_address_map.sv
// Self-checking bench for the self-programming sequencer
`timescale 1ns/10ps
module test_self_program_address_map;
    import sfp_pkg::*;

    logic        clk, resetn, sel_hi, sel_lo, we, re, spm, load_program_instr, done;
    logic        en, busy, halt, blk, bsel, fs, es, ws, ls;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rv;
    logic [15:0] z, sd, sdo, boot, aend;
    logic [5:0]  wsel;
    logic [6:0]  psel;
    int          bad_count, n_tests;
    logic [15:0] bs [4] = '{16'h1c00, 16'h1e00, 16'h1f00, 16'h1f80};
    logic [4:0]  badc [4] = '{5'h07, 5'h13, 5'h1f, 5'h02};
    logic [15:0] bw [1:2][4] = '{'{16'h3800, 16'h3c00, 16'h3e00, 16'h3f00},
                                 '{16'h7000, 16'h7800, 16'h7c00, 16'h7e00}};
    wire  [31:0] rdv [1:2];
    logic [31:0] rvw [1:2];

    sfp_seq #(.VARIANT(SFP_VAR_SMALL)) u_sfp_seq (
        .clk(clk), .resetn(resetn), .boot_size_sel_hi(sel_hi),
        .boot_size_sel_lo(sel_lo), .bus_addr(addr), .bus_wdata(wdata),
        .bus_we(we), .bus_re(re), .bus_rdata(rdata), .spm_exec(spm),
        .lpm_req(load_program_instr), .pointer_z(z), .store_data(sd), .flash_done(done),
        .store_prog_enable(en), .read_area_busy(busy), .cpu_halt(halt),
        .fill_strobe(fs), .erase_strobe(es), .write_strobe(ws),
        .lock_strobe(ls), .word_select_field(wsel),
        .page_select_field(psel), .store_data_out(sdo), .read_blocked(blk),
        .byte_select_bit(bsel), .boot_reset_addr(boot), .app_end_addr(aend)
    );
    // Wider variants share every input; their map reads are checked
    for (genvar v = 1; v < 3; v++)
    begin : g_var
        sfp_seq #(.VARIANT(v)) u_sfp_seq (
            .clk(clk), .resetn(resetn), .boot_size_sel_hi(sel_hi),
            .boot_size_sel_lo(sel_lo), .bus_addr(addr), .bus_wdata(wdata),
            .bus_we(we), .bus_re(re), .bus_rdata(rdv[v]), .spm_exec(spm),
            .lpm_req(load_program_instr), .pointer_z(z), .store_data(sd),
            .flash_done(done), .store_prog_enable(), .read_area_busy(),
            .cpu_halt(), .fill_strobe(), .erase_strobe(),
            .write_strobe(), .lock_strobe(), .word_select_field(),
            .page_select_field(), .store_data_out(), .read_blocked(),
            .byte_select_bit(), .boot_reset_addr(), .app_end_addr()
        );
    end
    sfp_cpu_model u_sfp_cpu_model (
        .clk(clk), .erase_strobe(es), .write_strobe(ws), .spm_exec(spm),
        .lpm_req(load_program_instr), .pointer_z(z), .store_data(sd), .flash_done(done)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Bus tasks start and end just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        we    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        re   <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 rv = rdata;
        rvw = rdv;
        @(posedge clk);
    endtask

    // Poll, command write, store with no gap between the last two
    task automatic cmd(input logic [4:0] c, input logic [15:0] zz,
                       input logic [15:0] dd);
        rv = 32'h1;
        for (int i = 0; i < 100 && rv[0]; i++)
            rd(SFP_CTRL_OFS);
        if (rv[0] !== 1'b0)
        begin
            check(rv, 32'h0);
            close_out;
        end
        wr(SFP_CTRL_OFS, {27'h0, c});
        u_sfp_cpu_model.store(zz, dd);
    endtask

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        resetn = 1'b0;
        sel_hi = 1'b1;
        sel_lo = 1'b1;
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 check(en, 0);
        @(posedge clk);
        rd(SFP_CTRL_OFS);
        check(rv, 32'h0);
        rd(8'h0c);
        check(rv, 32'h0);
        fin("reset");
        for (int k = 0; k < 4; k++)
        begin
            {sel_hi, sel_lo} <= k[1:0];
            repeat (5) @(posedge clk);
            rd(SFP_MAP_OFS);
            check(rv, {bs[k] - 16'h0001, bs[k]});
            check(boot, bs[k]);
            check(aend, bs[k] - 16'h0001);
            check(rvw[1], {bw[1][k] - 16'h0001, bw[1][k]});
            check(rvw[2], {bw[2][k] - 16'h0001, bw[2][k]});
        end
        rd(SFP_AREA_OFS);
        check(rv, 32'h1c00_000c);
        check(rvw[1], 32'h3800_000d);
        check(rvw[2], 32'h7000_000e);
        fin("map");
        wr(SFP_CTRL_OFS, 32'h1);
        repeat (3) @(posedge clk);
        #1 check(en, 1);
        @(posedge clk);
        u_sfp_cpu_model.store(16'h0002, 16'h1234);
        #1 check(en, 0);
        check(fs, 0);
        @(posedge clk);
        cmd(5'h01, 16'h0043, 16'hbeef);
        #1 check(fs, 1);
        check(wsel, 6'h21);
        check(sdo, 16'hbeef);
        @(posedge clk);
        wr(SFP_CTRL_OFS, 32'h1);
        repeat (3) @(posedge clk);
        u_sfp_cpu_model.store(16'h0004, 16'h5678);
        #1 check(fs, 1);
        check(wsel, 6'h02);
        fin("window");
        @(posedge clk);
        u_sfp_cpu_model.dly = 20;
        cmd(5'h03, 16'h3780, 16'h0);
        #1 check(es, 1);
        check(psel, 7'h6f);
        check(busy, 1);
        check(halt, 0);
        @(posedge clk);
        u_sfp_cpu_model.load(16'h37ff);
        #1 check(blk, 1);
        check(bsel, 1);
        check(en, 1);
        @(posedge clk);
        u_sfp_cpu_model.load(16'h3800);
        #1 check(blk, 0);
        check(bsel, 0);
        @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            rd(SFP_CTRL_OFS);
            if (rv[6] === 1'b0)
                break;
            cmd(5'h11, 16'h0, 16'h0);
        end
        check(rv[6], 0);
        fin("erase");
        u_sfp_cpu_model.dly = 2;
        cmd(5'h05, 16'h3800, 16'h0);
        #1 check(ws, 1);
        check(psel, 7'h70);
        check(halt, 1);
        check(busy, 0);
        repeat (8) @(posedge clk);
        #1 check(halt, 0);
        check(en, 0);
        @(posedge clk);
        cmd(5'h09, 16'h0, 16'h00fe);
        #1 check(ls, 1);
        check(sdo, 16'h00fe);
        @(posedge clk);
        foreach (badc[i])
        begin
            wr(SFP_CTRL_OFS, {27'h0, badc[i]});
            #1 check(en, 0);
            @(posedge clk);
        end
        fin("commands");
        close_out;
    end
endmodule
